// File: rtl/dbr_cfg.svh
// Timing counts, field codes and sizes for the DDR2 command and burst core.
`ifndef DBR_CFG_SVH
`define DBR_CFG_SVH

// ****************************************************************
// Clock and timing
// ****************************************************************
`define DBR_CLK_NS      50
`define DBR_TRFC_NS     128
`define DBR_TRFC_CYC    ((`DBR_TRFC_NS + `DBR_CLK_NS - 1) / `DBR_CLK_NS)
`define DBR_TXSNR_NS    138
`define DBR_TXSNR_CYC   ((`DBR_TXSNR_NS + `DBR_CLK_NS - 1) / `DBR_CLK_NS)
`define DBR_TREFI_NS    7800
`define DBR_TREFI_CYC   (`DBR_TREFI_NS / `DBR_CLK_NS)
`define DBR_TMR_W       8

// ****************************************************************
// Mode fields and sizes
// ****************************************************************
`define DBR_BL4_CODE    3'h2
`define DBR_BL8_CODE    3'h3
`define DBR_AL_MAX      3'h6
`define DBR_DLY_DEPTH   12
`define DBR_ROW_W       14
`define DBR_COL_W       10
`define DBR_BANKS       8

`endif

// File: rtl/dbr_pkg.sv
// Shared types for the DDR2 command and burst core.
package dbr_pkg;

    // Decoded command on one rising clock edge.
    typedef enum logic [2:0] {
        DBR_CMD_NOP,
        DBR_CMD_ACT,
        DBR_CMD_RD,
        DBR_CMD_WR,
        DBR_CMD_REF,
        DBR_CMD_SRE,
        DBR_CMD_PRE,
        DBR_CMD_OTHER
    } dbr_cmd_e;

    // Power and refresh state of the device.
    typedef enum logic [1:0] {
        DBR_ST_ACTIVE,
        DBR_ST_SELF,
        DBR_ST_EXIT
    } dbr_state_e;

endpackage

// File: rtl/dbr_burst_seq.sv
// Column offset of one burst beat from start address, length and order.
`timescale 1ns/1ns

module dbr_burst_seq (
    input  wire logic [2:0] start_col,
    input  wire logic [2:0] beat,
    input  wire logic       bl8,
    input  wire logic       interleave,
    output logic      [2:0] offset
);

    // ****************************************************************
    // Beat ordering
    // ****************************************************************

    // Sequential order wraps the low two bits; interleave XORs them.
    // Bit 2 flips only in the second nibble of a length-eight burst,
    // so a length-four burst never leaves its aligned group of four.
    always_comb begin
        offset[1:0] = start_col[1:0] + beat[1:0];
        if (interleave) begin
            offset[1:0] = start_col[1:0] ^ beat[1:0];
        end
        offset[2] = bl8 ? (start_col[2] ^ beat[2]) : start_col[2];
    end

endmodule // dbr_burst_seq

// File: rtl/dbr_core.sv
// Device-side DDR2 command decoder, refresh, self refresh and burst core.
`timescale 1ns/1ns
`include "dbr_cfg.svh"

module dbr_core (
    input  wire logic                   clock,
    input  wire logic                   rst_b,
    input  wire logic                   cke,
    input  wire logic                   cs_b,
    input  wire logic                   ras_b,
    input  wire logic                   cas_b,
    input  wire logic                   we_b,
    input  wire logic [2:0]             ba,
    input  wire logic [`DBR_ROW_W-1:0]  addr,
    input  wire logic [2:0]             mr_burst_len,
    input  wire logic                   mr_interleave,
    input  wire logic [2:0]             mr_cas_lat,
    input  wire logic [2:0]             emr_add_lat,
    output logic [`DBR_ROW_W-1:0]       refresh_row,
    output logic                        refresh_busy,
    output logic                        refresh_done,
    output logic [`DBR_BANKS-1:0]       banks_open,
    output logic                        sr_active,
    output logic                        exit_busy,
    output logic                        col_issue,
    output logic                        col_issue_wr,
    output logic [2:0]                  col_issue_bank,
    output logic                        burst_valid,
    output logic                        burst_write,
    output logic [2:0]                  burst_bank,
    output logic [`DBR_COL_W-1:0]       burst_col_a,
    output logic [`DBR_COL_W-1:0]       burst_col_b
);

    // ****************************************************************
    // Decode helpers
    // ****************************************************************

    // Turns the sampled pins into one command; deselect reads as NOP.
    function automatic dbr_pkg::dbr_cmd_e decode(
        input logic cke_now,
        input logic cke_prev,
        input logic sel_b,
        input logic [2:0] rcw
    );
        dbr_pkg::dbr_cmd_e c;
        c = dbr_pkg::DBR_CMD_NOP;
        if (!sel_b) begin
            case (rcw)
                3'h3: c = dbr_pkg::DBR_CMD_ACT;
                3'h5: c = dbr_pkg::DBR_CMD_RD;
                3'h4: c = dbr_pkg::DBR_CMD_WR;
                3'h2: c = dbr_pkg::DBR_CMD_PRE;
                3'h7: c = dbr_pkg::DBR_CMD_NOP;
                3'h1: begin
                    if (cke_now) begin
                        c = dbr_pkg::DBR_CMD_REF;
                    end else if (cke_prev) begin
                        c = dbr_pkg::DBR_CMD_SRE;
                    end
                end
                default: c = dbr_pkg::DBR_CMD_OTHER;
            endcase
        end
        return c;
    endfunction

    // Index into the delay line, clamped so small settings stay legal.
    function automatic logic [3:0] line_idx(
        input logic [3:0] lat,
        input logic [3:0] back
    );
        return (lat >= back) ? 4'(lat - back) : 4'h0;
    endfunction

    // ****************************************************************
    // Command decode
    // ****************************************************************

    dbr_pkg::dbr_state_e    state;
    dbr_pkg::dbr_state_e    next_state;
    dbr_pkg::dbr_cmd_e      cmd;
    logic                   cke_prev;
    logic                   col_in;
    logic                   bl8;

    assign cmd = decode(cke, cke_prev, cs_b, {ras_b, cas_b, we_b});
    assign col_in = (state == dbr_pkg::DBR_ST_ACTIVE) && !cs_b &&
                    (cmd == dbr_pkg::DBR_CMD_RD ||
                     cmd == dbr_pkg::DBR_CMD_WR);
    // length field, unsupported codes fall back to four.
    assign bl8 = (mr_burst_len == `DBR_BL8_CODE);

    // ****************************************************************
    // Refresh and self refresh
    // ****************************************************************

    logic [`DBR_TMR_W-1:0]  busy_cnt;
    logic [`DBR_TMR_W-1:0]  next_busy_cnt;
    logic [`DBR_TMR_W-1:0]  sr_cnt;
    logic [`DBR_TMR_W-1:0]  next_sr_cnt;
    logic [`DBR_ROW_W-1:0]  next_row;
    logic [`DBR_BANKS-1:0]  next_banks;
    logic                   ref_needed;
    logic                   next_ref_needed;
    logic                   next_ref_done;

    assign refresh_busy = (busy_cnt != '0);
    assign sr_active    = (state == dbr_pkg::DBR_ST_SELF);
    assign exit_busy    = (state == dbr_pkg::DBR_ST_EXIT);

    // The internal timer stands in for the stopped clock in self refresh.
    always_comb begin
        next_state      = state;
        next_busy_cnt   = busy_cnt;
        next_sr_cnt     = sr_cnt;
        next_row        = refresh_row;
        next_banks      = banks_open;
        next_ref_needed = ref_needed;
        next_ref_done   = 1'b0;
        case (state)
            dbr_pkg::DBR_ST_ACTIVE: begin
                if (busy_cnt != '0) begin
                    next_busy_cnt = busy_cnt - 1'b1;
                end
                case (cmd)
                    dbr_pkg::DBR_CMD_ACT: next_banks[ba] = 1'b1;
                    dbr_pkg::DBR_CMD_PRE: begin
                        if (addr[10]) begin
                            next_banks = '0;
                        end else begin
                            next_banks[ba] = 1'b0;
                        end
                    end
                    dbr_pkg::DBR_CMD_REF: begin
                        if (busy_cnt == '0) begin
                            next_row        = refresh_row + 1'b1;
                            next_busy_cnt   = `DBR_TMR_W'(`DBR_TRFC_CYC);
                            next_ref_needed = 1'b0;
                        end
                    end
                    dbr_pkg::DBR_CMD_SRE: begin
                        if (busy_cnt == '0 && !ref_needed) begin
                            next_state  = dbr_pkg::DBR_ST_SELF;
                            next_sr_cnt = `DBR_TMR_W'(`DBR_TREFI_CYC);
                            next_banks  = '0;
                        end
                    end
                    default: ;
                endcase
                if (busy_cnt == `DBR_TMR_W'(1)) begin
                    next_banks    = '0;
                    next_ref_done = 1'b1;
                end
            end
            dbr_pkg::DBR_ST_SELF: begin
                if (cke) begin
                    next_state  = dbr_pkg::DBR_ST_EXIT;
                    next_sr_cnt = `DBR_TMR_W'(`DBR_TXSNR_CYC);
                end else if (sr_cnt == `DBR_TMR_W'(1)) begin
                    next_row    = refresh_row + 1'b1;
                    next_sr_cnt = `DBR_TMR_W'(`DBR_TREFI_CYC);
                end else begin
                    next_sr_cnt = sr_cnt - 1'b1;
                end
            end
            dbr_pkg::DBR_ST_EXIT: begin
                next_sr_cnt = sr_cnt - 1'b1;
                if (sr_cnt == `DBR_TMR_W'(1)) begin
                    next_state = dbr_pkg::DBR_ST_ACTIVE;
                    next_ref_needed = 1'b1;
                end
            end
            default: next_state = dbr_pkg::DBR_ST_ACTIVE;
        endcase
    end

    // Registers of the refresh and power state.
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            state        <= dbr_pkg::DBR_ST_ACTIVE;
            cke_prev     <= 1'b0;
            busy_cnt     <= '0;
            sr_cnt       <= '0;
            refresh_row  <= '0;
            banks_open   <= '0;
            ref_needed   <= 1'b0;
            refresh_done <= 1'b0;
        end else begin
            state        <= next_state;
            cke_prev     <= cke;
            busy_cnt     <= next_busy_cnt;
            sr_cnt       <= next_sr_cnt;
            refresh_row  <= next_row;
            banks_open   <= next_banks;
            ref_needed   <= next_ref_needed;
            refresh_done <= next_ref_done;
        end
    end

    // ****************************************************************
    // Posted column delay line
    // ****************************************************************

    logic                   dl_v [`DBR_DLY_DEPTH];
    logic                   dl_w [`DBR_DLY_DEPTH];
    logic [2:0]             dl_b [`DBR_DLY_DEPTH];
    logic [`DBR_COL_W-1:0]  dl_c [`DBR_DLY_DEPTH];
    logic                   next_dl_v [`DBR_DLY_DEPTH];
    logic                   next_dl_w [`DBR_DLY_DEPTH];
    logic [2:0]             next_dl_b [`DBR_DLY_DEPTH];
    logic [`DBR_COL_W-1:0]  next_dl_c [`DBR_DLY_DEPTH];
    logic [2:0]             al;
    logic [3:0]             rl;
    logic [3:0]             al_i;
    logic [3:0]             rd_i;
    logic [3:0]             wr_i;
    logic                   next_issue;
    logic                   next_issue_wr;
    logic [2:0]             next_issue_bank;

    assign al = (emr_add_lat > `DBR_AL_MAX) ? `DBR_AL_MAX : emr_add_lat;
    // read latency sum, write one less
    assign rl   = 4'(al) + 4'(mr_cas_lat);
    assign al_i = line_idx(4'(al), 4'h1);
    assign rd_i = line_idx(rl, 4'h2);
    assign wr_i = line_idx(rl, 4'h3);

    // Entry i holds the column command taken i+1 edges ago.
    always_comb begin
        next_dl_v[0] = col_in;
        next_dl_w[0] = (cmd == dbr_pkg::DBR_CMD_WR);
        next_dl_b[0] = ba;
        next_dl_c[0] = addr[`DBR_COL_W-1:0];
        for (int i = 1; i < `DBR_DLY_DEPTH; i++) begin
            next_dl_v[i] = dl_v[i-1];
            next_dl_w[i] = dl_w[i-1];
            next_dl_b[i] = dl_b[i-1];
            next_dl_c[i] = dl_c[i-1];
        end
        if (al == 3'h0) begin
            next_issue      = col_in;
            next_issue_wr   = next_dl_w[0];
            next_issue_bank = ba;
        end else begin
            next_issue      = dl_v[al_i];
            next_issue_wr   = dl_w[al_i];
            next_issue_bank = dl_b[al_i];
        end
    end

    // The line only shifts; reset clears the valid bits alone.
    always_ff @(posedge clock) begin
        for (int i = 0; i < `DBR_DLY_DEPTH; i++) begin
            dl_v[i] <= rst_b ? next_dl_v[i] : 1'b0;
            dl_w[i] <= next_dl_w[i];
            dl_b[i] <= next_dl_b[i];
            dl_c[i] <= next_dl_c[i];
        end
        if (!rst_b) begin
            col_issue      <= 1'b0;
            col_issue_wr   <= 1'b0;
            col_issue_bank <= 3'h0;
        end else begin
            col_issue      <= next_issue;
            col_issue_wr   <= next_issue_wr;
            col_issue_bank <= next_issue_bank;
        end
    end

    // ****************************************************************
    // Burst sequencer
    // ****************************************************************

    logic                   start_rd;
    logic                   start_wr;
    logic [1:0]             pair;
    logic [1:0]             next_pair;
    logic [`DBR_COL_W-1:0]  base;
    logic [`DBR_COL_W-1:0]  next_base;
    logic                   next_bvalid;
    logic                   next_bwrite;
    logic [2:0]             next_bbank;
    logic [2:0]             off_a;
    logic [2:0]             off_b;

    assign start_rd = dl_v[rd_i] && !dl_w[rd_i];
    assign start_wr = dl_v[wr_i] && dl_w[wr_i];

    // A new start simply restarts the burst; there is no stop command.
    // Reads win a clash, which only an illegal command mix can cause.
    always_comb begin
        next_bvalid = burst_valid;
        next_bwrite = burst_write;
        next_bbank  = burst_bank;
        next_base   = base;
        next_pair   = pair;
        if (start_rd || start_wr) begin
            next_bvalid = 1'b1;
            next_bwrite = !start_rd;
            next_bbank  = start_rd ? dl_b[rd_i] : dl_b[wr_i];
            next_base   = start_rd ? dl_c[rd_i] : dl_c[wr_i];
            next_pair   = 2'h0;
        end else if (burst_valid) begin
            if (pair == (bl8 ? 2'h3 : 2'h1)) begin
                next_bvalid = 1'b0;
            end else begin
                next_pair = pair + 2'h1;
            end
        end
    end

    // Two beats per clock, one for each data edge.
    dbr_burst_seq u_seq_a (
        .start_col  (next_base[2:0]),
        .beat       ({next_pair, 1'b0}),
        .bl8        (bl8),
        .interleave (mr_interleave),
        .offset     (off_a)
    );

    dbr_burst_seq u_seq_b (
        .start_col  (next_base[2:0]),
        .beat       ({next_pair, 1'b1}),
        .bl8        (bl8),
        .interleave (mr_interleave),
        .offset     (off_b)
    );

    // Burst registers; column outputs hold after the burst ends.
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            burst_valid <= 1'b0;
            burst_write <= 1'b0;
            burst_bank  <= 3'h0;
            base        <= '0;
            pair        <= 2'h0;
            burst_col_a <= '0;
            burst_col_b <= '0;
        end else begin
            burst_valid <= next_bvalid;
            burst_write <= next_bwrite;
            burst_bank  <= next_bbank;
            base        <= next_base;
            pair        <= next_pair;
            burst_col_a <= {next_base[`DBR_COL_W-1:3], off_a};
            burst_col_b <= {next_base[`DBR_COL_W-1:3], off_b};
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    property p_ref_row;
        (cmd == dbr_pkg::DBR_CMD_REF && !sr_active && !exit_busy &&
         !refresh_busy) |=>
            refresh_row == $past(refresh_row) + 1'b1
            ##1 refresh_busy [*2] ##1 !refresh_busy;
    endproperty
    a_ref_row: assert property (p_ref_row)
        else $error("refresh did not advance row or keep busy");

    property p_ref_idle;
        $fell(refresh_busy) |-> (banks_open == 8'h00) && refresh_done;
    endproperty
    a_ref_idle: assert property (p_ref_idle)
        else $error("banks not idle after refresh");

    property p_nop;
        (cmd == dbr_pkg::DBR_CMD_NOP && state == dbr_pkg::DBR_ST_ACTIVE &&
         !refresh_busy) |=>
            $stable(banks_open) && $stable(refresh_row);
    endproperty
    a_nop: assert property (p_nop)
        else $error("no-operation changed state");

    property p_deselect;
        cs_b |-> !col_in ##1 ($stable(banks_open) || $past(refresh_busy));
    endproperty
    a_deselect: assert property (p_deselect)
        else $error("deselect did not ignore inputs");

    property p_group;
        burst_valid |-> burst_col_a[9:3] == burst_col_b[9:3] &&
            (pair == 2'h0 || (burst_col_a[9:3] == $past(burst_col_a[9:3]) &&
             (bl8 || burst_col_a[2] == $past(burst_col_a[2]))));
    endproperty
    a_group: assert property (p_group)
        else $error("burst left its column group");

    property p_posted;
        (col_in && al == 3'h2) |-> ##3 col_issue;
    endproperty
    a_posted: assert property (p_posted)
        else $error("column command not issued after additive latency");

    property p_rd_lat;
        (col_in && cmd == dbr_pkg::DBR_CMD_RD && al == 3'h0 &&
         mr_cas_lat == 3'h3) |-> ##3 (burst_valid && !burst_write);
    endproperty
    a_rd_lat: assert property (p_rd_lat)
        else $error("read burst not at read latency");

    property p_seq;
        (burst_valid && !mr_interleave) |->
            burst_col_b[1:0] == burst_col_a[1:0] + 2'h1;
    endproperty
    a_seq: assert property (p_seq)
        else $error("sequential beat order wrong");

    property p_intl;
        (burst_valid && mr_interleave) |->
            (burst_col_a[2:0] ^ burst_col_b[2:0]) == 3'h1;
    endproperty
    a_intl: assert property (p_intl)
        else $error("interleaved beat order wrong");

    property p_sre;
        (cmd == dbr_pkg::DBR_CMD_SRE && state == dbr_pkg::DBR_ST_ACTIVE &&
         !refresh_busy && !ref_needed) |=> sr_active;
    endproperty
    a_sre: assert property (p_sre)
        else $error("self refresh not entered");

endmodule // dbr_core

// File: testbench/dbr_ctl_model.sv
// Controller model driving the DDR2 command pins on falling edges.
`timescale 1ns/1ns
`include "dbr_cfg.svh"

module dbr_ctl_model (
    input  wire logic             clock,
    output logic                  cke,
    output logic                  cs_b,
    output logic                  ras_b,
    output logic                  cas_b,
    output logic                  we_b,
    output logic [2:0]            ba,
    output logic [`DBR_ROW_W-1:0] addr
);
    logic                  pend = 1'b0;
    logic                  cke_lvl = 1'b1;
    logic                  tog = 1'b0;
    logic [2:0]            p_rcw, p_ba;
    logic [`DBR_ROW_W-1:0] p_addr;

    initial {cke, cs_b, ras_b, cas_b, we_b, ba, addr} = '1;

    // queued command, idle fill
    // No termination pin is modelled, so termination stays off throughout.
    // A queued command stands one cycle; otherwise NOP and deselect take
    // turns, and a deselected bus flips so stale pins never look held.
    always @(negedge clock) begin
        tog = ~tog;
        cke <= cke_lvl;
        if (pend) begin
            {cs_b, ras_b, cas_b, we_b} <= {1'b0, p_rcw};
            {ba, addr} <= {p_ba, p_addr};
            pend = 1'b0;
        end else begin
            cs_b <= tog;
            {ras_b, cas_b, we_b} <= tog ? ~{ras_b, cas_b, we_b} : 3'h7;
            {ba, addr} <= ~{ba, addr};
        end
    end
endmodule // dbr_ctl_model

// File: testbench/ddr2_refresh_burst_access_tb_top.sv
// Self-checking bench for the DDR2 command and burst core.
`timescale 1ns/1ns
`include "dbr_cfg.svh"

module ddr2_refresh_burst_access_tb_top;
    logic                  clock = 1'b0;
    logic                  rst_b = 1'b0;
    logic                  cke, cs_b, ras_b, cas_b, we_b, sr_active;
    logic                  mr_interleave, refresh_busy, refresh_done;
    logic                  exit_busy, col_issue, col_issue_wr;
    logic                  burst_valid, burst_write, wr, b8;
    logic [2:0]            ba, mr_burst_len, mr_cas_lat, emr_add_lat;
    logic [2:0]            col_issue_bank, burst_bank;
    logic [`DBR_ROW_W-1:0] addr, refresh_row;
    logic [`DBR_BANKS-1:0] banks_open;
    logic [9:0]            burst_col_a, burst_col_b, col;
    logic [31:0]           rnd = 32'h42bd;
    int                    error_cnt = 0;
    int                    tests_run = 0;
    int                    exp_row = 0;
    int                    al, rl, len, k;
    logic [3:0]            wb;

    dbr_core u_dut (.clock(clock), .rst_b(rst_b), .cke(cke), .cs_b(cs_b),
        .ras_b(ras_b), .cas_b(cas_b), .we_b(we_b), .ba(ba), .addr(addr),
        .mr_burst_len(mr_burst_len), .mr_interleave(mr_interleave),
        .mr_cas_lat(mr_cas_lat), .emr_add_lat(emr_add_lat),
        .refresh_row(refresh_row), .refresh_busy(refresh_busy),
        .refresh_done(refresh_done), .banks_open(banks_open),
        .sr_active(sr_active), .exit_busy(exit_busy),
        .col_issue(col_issue), .col_issue_wr(col_issue_wr),
        .col_issue_bank(col_issue_bank), .burst_valid(burst_valid),
        .burst_write(burst_write), .burst_bank(burst_bank),
        .burst_col_a(burst_col_a), .burst_col_b(burst_col_b));

    dbr_ctl_model u_ctl (.clock(clock), .cke(cke), .cs_b(cs_b),
        .ras_b(ras_b), .cas_b(cas_b), .we_b(we_b), .ba(ba), .addr(addr));

    // Free-running clock, so it is always stable before an exit.
    initial begin
        forever #25 clock = ~clock;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Column of beat k; the group bits above never move.
    function automatic logic [9:0] ecol(input logic [9:0] s, input int k);
        logic [2:0] o;
        o = mr_interleave ? s[2:0] ^ k[2:0] : {s[2] ^ k[2], s[1:0] + k[1:0]};
        if (!b8)
            o[2] = s[2];
        return {s[9:3], o};
    endfunction

    task automatic chk(input string nm, input logic [31:0] s, e);
        tests_run++;
        if (s !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %0h seen %0h", nm, e, s);
        end
    endtask

    // callers keep spacing
    // Queues a command; returns at the falling edge that puts it out.
    task automatic cmd(input logic [2:0] rcw, input logic [13:0] a,
                       input logic c);
        #1;
        {u_ctl.p_rcw, u_ctl.p_ba, u_ctl.p_addr} = {rcw, rnd[2:0], a};
        u_ctl.cke_lvl = c;
        u_ctl.pend = 1'b1;
        @(negedge clock);
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Watchdog well past the roughly 600 cycles the tests need.
    initial begin
        repeat (5000) @(posedge clock);
        error_cnt++;
        end_sim();
    end

    initial begin
        {mr_interleave, mr_burst_len, mr_cas_lat, emr_add_lat} = 10'h0c;
        repeat (10) @(negedge clock);
        rst_b <= 1'b1;
        @(negedge clock);
        // Open a bank with random bank and address pins, then check it.
        cmd(3'b011, rnd[13:0], 1'b1);
        @(negedge clock);
        chk("open", banks_open, 8'h1 << rnd[2:0]);
        // Close the bank, reopen it, and refresh straight after.
        cmd(3'b010, 14'h0, 1'b1);
        @(negedge clock);
        chk("pre", banks_open, 0);
        cmd(3'b011, 14'h0, 1'b1);
        cmd(3'b001, ~rnd[13:0], 1'b1);
        for (int n = 1; n < 6; n++) begin
            @(negedge clock);
            chk("row", refresh_row, exp_row + 1);
            chk("busy", refresh_busy, n < 4);
            chk("done", refresh_done, n == 4);
        end
        chk("banks", banks_open, 0);
        exp_row++;
        // Idle fill includes deselected all-low ras_b, cas_b, we_b patterns; nothing starts.
        repeat (8) begin
            @(negedge clock);
            chk("idle", {refresh_busy, col_issue}, 0);
        end
        $display("test refresh ended");
        for (int t = 0; t < 16; t++) begin
            // The last command must leave the delay line before the
            // latencies move, or a stale entry would start a burst.
            repeat (`DBR_DLY_DEPTH) @(negedge clock);
            repeat (8) rnd = lfsr(rnd);
            {col, b8, wr, mr_interleave} = rnd[12:0];
            al = rnd[15:13] % 7;
            mr_burst_len = b8 ? `DBR_BL8_CODE : `DBR_BL4_CODE;
            mr_cas_lat = 3'h3 + {1'b0, rnd[17:16]};
            emr_add_lat = al[2:0];
            rl = al + mr_cas_lat - wr;
            len = b8 ? 4 : 2;
            wb = {wr, rnd[2:0]};
            cmd(wr ? 3'b100 : 3'b101, {4'h0, col}, 1'b1);
            for (int n = 1; n <= rl + len; n++) begin
                @(negedge clock);
                k = 2 * (n - rl);
                chk("issue", col_issue, n == al + 1);
                if (n == al + 1)
                    chk("iwr", {col_issue_wr, col_issue_bank}, wb);
                chk("valid", burst_valid, n >= rl && n < rl + len);
                if (n >= rl && n < rl + len) begin
                    chk("dir", {burst_write, burst_bank}, wb);
                    chk("col_a", burst_col_a, ecol(col, k));
                    chk("col_b", burst_col_b, ecol(col, k + 1));
                end
            end
        end
        $display("test bursts ended");
        cmd(3'b001, 14'h0, 1'b0);
        @(negedge clock);
        chk("sr", sr_active, 1);
        repeat (160) @(negedge clock);
        chk("sr_row", refresh_row, exp_row + 1);
        exp_row++;
        #1 u_ctl.cke_lvl = 1'b1;
        @(negedge clock);
        for (int n = 1; n < 6; n++) begin
            @(negedge clock);
            chk("exit", {sr_active, exit_busy}, n < 4);
        end
        // Re-entry before a refresh is refused.
        cmd(3'b001, 14'h0, 1'b0);
        #1 u_ctl.cke_lvl = 1'b1;
        @(negedge clock);
        chk("resr", sr_active, 0);
        cmd(3'b001, 14'h0, 1'b1);
        @(negedge clock);
        chk("ref", refresh_row, exp_row + 1);
        $display("test self refresh ended");
        end_sim();
    end
endmodule // ddr2_refresh_burst_access_tb_top
